/* File: bench/bipolar_stepper_phase_sequencer_tb.sv */
// Testbench of the stepper phase sequencer against an integer reference model.
`timescale 1ns/100ps
module bipolar_stepper_phase_sequencer_tb;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        step_clk_pin;
    logic [3:0]  coil_hs_on;
    logic [3:0]  coil_ls_on;
    logic        home_o;
    logic        home_oe_n;
    logic [7:0]  bias_current;
    logic        fire;
    logic        busy;
    logic        shoot;
    logic [3:0]  ctrl;
    logic [31:0] seed;
    logic [31:0] rd;
    int          num_errors;
    int          tests_run;
    int          ph;
    int          cnt;
    int          cycles = 0;
    int          c1 [8] = '{1, 0, -1, -1, -1, 0, 1, 1};
    int          c2 [8] = '{1, 1, 1, 0, -1, -1, -1, 0};
    logic [3:0]  seq [24] = '{0, 0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2, 2, 2, 6, 6, 6, 0, 7, 7, 1};

    bps_sequencer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .step_clk_pin(step_clk_pin), .coil_hs_on(coil_hs_on),
        .coil_ls_on(coil_ls_on), .home_phase_indicator_o(home_o), .home_phase_indicator_oe_n(home_oe_n),
        .bias_current(bias_current));

    bps_motor_model mot_u (.hclk(hclk), .hresetn(hresetn), .fire(fire), .coil_hs_on(coil_hs_on),
        .coil_ls_on(coil_ls_on), .step_clk_pin(step_clk_pin), .busy(busy), .shoot(shoot));

    // Free-running bus clock.
    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // Cycle ceiling cuts a hung run short.
    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected indicator enable, low sides and high sides for the model phase.
    function automatic logic [8:0] exp_pins();
        logic [3:0] hs;
        logic [3:0] ls;
        int         p [2];
        hs = 4'h0;
        ls = 4'h0;
        p[0] = c1[ph];
        p[1] = c2[ph];
        for (int k = 0; k < 2; k++)
            if (p[k] == 1)
                {ls[2*k+1], hs[2*k]} = 2'h3;
            else if (p[k] == -1)
                {hs[2*k+1], ls[2*k]} = 2'h3;
            else if (ctrl[1] && ctrl[2])
                hs[2*k +: 2] = 2'h3;
        if (ctrl[3])
            {hs, ls} = 8'h00;
        return {ph != 0, ls, hs};
    endfunction

    function automatic logic [31:0] status();
        logic [8:0] e;
        e = exp_pins();
        return {19'h0, ctrl[3], e[7:0], ph == 0, ph[2:0]};
    endfunction

    // Next phase: half steps move by one, full steps to the next even phase.
    function automatic int nxt();
        int s;
        s = (ctrl[1] || ph % 2 == 1) ? 1 : 2;
        return ctrl[0] ? (ph + 8 - s) % 8 : (ph + s) % 8;
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Single AHB-Lite transfer; read data is taken at the edge that ends the data phase.
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        q = hrdata;
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
        ahb(a, 1'b0, 32'h0, rd);
        cmp(rd, e);
        cmp({31'h0, hresp}, 32'h0);
    endtask

    task automatic chk_pins();
        cmp({22'h0, home_o | shoot, home_oe_n, coil_ls_on, coil_hs_on}, {23'h0, exp_pins()});
    endtask

    task automatic set_ctrl(input logic [3:0] v);
        ahb(bps_pkg::CTRL_OFS, 1'b1, {28'h0, v}, rd);
        ctrl = v;
        if (v[3])
            ph = 0;
        repeat (2) @(posedge hclk);
        chk_pins();
    endtask

    // One step from the pin or the step register, then model update and pin check.
    task automatic step(input logic pin);
        if (pin)
        begin
            fire <= 1'b1;
            @(posedge hclk);
            fire <= 1'b0;
            @(posedge hclk);
            while (busy)
                @(posedge hclk);
        end
        else
            ahb(bps_pkg::STEP_OFS, 1'b1, 32'h1, rd);
        repeat (3) @(posedge hclk);
        if (!ctrl[3])
        begin
            ph = nxt();
            cnt++;
        end
        chk_pins();
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Main sequence: reset with the set line open, release, directed and random stepping.
    initial
    begin
        {hresetn, hsel, haddr, htrans, hwrite, hwdata, fire} = '0;
        hsize = 3'h2;
        {num_errors, tests_run, ph, cnt} = '0;
        ctrl = bps_pkg::CTRL_RST;
        seed = 32'h9C55;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk_pins();
        chk_reg(bps_pkg::CTRL_OFS, {28'h0, bps_pkg::CTRL_RST});
        chk_reg(bps_pkg::BIAS_OFS, {24'h0, bps_pkg::BIAS_RST});
        chk_reg(8'h14, 32'h0);
        step(1'b1);
        step(1'b0);
        chk_reg(bps_pkg::STATUS_OFS, status());
        set_ctrl(4'h0);
        chk_reg(bps_pkg::STEPCNT_OFS, 32'h0);
        foreach (seq[i])
        begin
            set_ctrl(seq[i]);
            step(i[0]);
        end
        for (int n = 0; n < 40; n++)
        begin
            seed = lfsr(seed);
            set_ctrl({1'b0, seed[2:0]});
            step(seed[3]);
            chk_reg(bps_pkg::STATUS_OFS, status());
        end
        chk_reg(bps_pkg::STEPCNT_OFS, cnt);
        ahb(bps_pkg::STATUS_OFS, 1'b1, 32'hFFFF, rd);
        chk_reg(bps_pkg::STATUS_OFS, status());
        ahb(bps_pkg::BIAS_OFS, 1'b1, 32'h5, rd);
        @(posedge hclk);
        cmp({24'h0, bias_current}, 32'h5);
        chk_pins();
        ahb(bps_pkg::STEPCNT_OFS, 1'b1, 32'h0, rd);
        cnt = 0;
        chk_reg(bps_pkg::STEPCNT_OFS, 32'h0);
        set_ctrl(4'hB);
        step(1'b1);
        set_ctrl(4'h7);
        step(1'b1);
        chk_reg(bps_pkg::STATUS_OFS, status());
        chk_reg(bps_pkg::STEPCNT_OFS, cnt);
        tally_and_finish();
    end
endmodule

/* File: bench/bps_motor_model.sv */
// Step controller and coil model that issues timed step pulses and watches the coil switches.
`timescale 1ns/100ps
module bps_motor_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       fire,
    input  wire logic [3:0] coil_hs_on,
    input  wire logic [3:0] coil_ls_on,
    output logic            step_clk_pin,
    output logic            busy,
    output logic            shoot
);
    logic [3:0] left_r;

    // Pulse timer keeps the pin high four cycles and low four, above the three-cycle minimum of each level.
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            left_r <= 4'h0;
        else if (fire && left_r == 4'h0)
            left_r <= 4'h8;
        else if (left_r != 4'h0)
            left_r <= left_r - 4'h1;

    // The pin rises on the edge after a request and idles low between pulses.
    assign step_clk_pin = left_r > 4'h4;
    assign busy         = left_r != 4'h0;
    // A leg with both switches on would short the supply, so it is flagged.
    assign shoot = |(coil_hs_on & coil_ls_on);
endmodule

/* File: hw/bps_coil_decode.sv */
// Coil switch decoder: turns the phase into high-side and low-side switch controls.
`timescale 1ns/100ps
module bps_coil_decode (
    input wire logic hclk,
    input wire logic hresetn,
    bps_drv_if.dec   drv
);

    logic [7:0] on_tab [2];
    logic [7:0] pos_tab[2];

    assign on_tab[0]  = bps_pkg::COIL1_ON;
    assign on_tab[1]  = bps_pkg::COIL2_ON;
    assign pos_tab[0] = bps_pkg::COIL1_POS;
    assign pos_tab[1] = bps_pkg::COIL2_POS;

    // Switch registers; a set line open or reset leaves every switch off.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            drv.hs_on <= 4'h0;
            drv.ls_on <= 4'h0;
        end
        else
        begin
            for (int k = 0; k < 2; k++)
            begin
                if (drv.set_open)
                begin
                    drv.hs_on[2*k]   <= 1'b0;
                    drv.ls_on[2*k]   <= 1'b0;
                    drv.hs_on[2*k+1] <= 1'b0;
                    drv.ls_on[2*k+1] <= 1'b0;
                end
                else if (on_tab[k][drv.phase])
                begin
                    drv.hs_on[2*k]   <= pos_tab[k][drv.phase];
                    drv.ls_on[2*k]   <= !pos_tab[k][drv.phase];
                    drv.hs_on[2*k+1] <= !pos_tab[k][drv.phase];
                    drv.ls_on[2*k+1] <= pos_tab[k][drv.phase];
                end
                else
                begin
                    drv.hs_on[2*k]   <= drv.half_mode && drv.idle_low_z;
                    drv.ls_on[2*k]   <= 1'b0;
                    drv.hs_on[2*k+1] <= drv.half_mode && drv.idle_low_z;
                    drv.ls_on[2*k+1] <= 1'b0;
                end
            end
        end
    end

    // Home indicator follows the phase, and turns on at the same edge as the switches go off when the set line opens.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            drv.home_on <= 1'b1;
        else
            drv.home_on <= drv.set_open || (drv.phase == bps_pkg::BPS_PH_A);
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_NO_SHOOT_THROUGH: assert property ((drv.hs_on & drv.ls_on) == 4'h0)
        else $error("High and low switch of one output both on.");
    AST_FULL_BOTH_COILS: assert property (!drv.set_open && !drv.phase[0] |=>
        (drv.hs_on | drv.ls_on) == 4'hF)
        else $error("Even phase does not energize both coils.");
    AST_IDLE_HIZ: assert property (!drv.set_open && drv.phase[0] && !drv.idle_low_z |=>
        $countones(drv.hs_on | drv.ls_on) == 2)
        else $error("Idle coil not high impedance.");
    AST_IDLE_LOWZ: assert property (!drv.set_open && drv.phase[0] && drv.half_mode && drv.idle_low_z |=>
        $countones(drv.hs_on) == 3 && $countones(drv.ls_on) == 1)
        else $error("Idle coil high sides not both on.");

endmodule

/* File: hw/bps_drv_if.sv */
// Interface between the sequencer and the coil decoder.
`timescale 1ns/100ps
interface bps_drv_if;
    bps_pkg::bps_phase_t phase;
    logic                half_mode;
    logic                idle_low_z;
    logic                set_open;
    logic [3:0]          hs_on;
    logic [3:0]          ls_on;
    logic                home_on;

    modport seq (output phase, half_mode, idle_low_z, set_open, input hs_on, ls_on, home_on);
    modport dec (input phase, half_mode, idle_low_z, set_open, output hs_on, ls_on, home_on);
endinterface

/* File: hw/bps_pkg.sv */
// Package with register map, field layout, reset values and phase codes of the stepper sequencer.
package bps_pkg;

    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS    = 8'h00;
    localparam logic [7:0] BIAS_OFS    = 8'h04;
    localparam logic [7:0] STEP_OFS    = 8'h08;
    localparam logic [7:0] STATUS_OFS  = 8'h0C;
    localparam logic [7:0] STEPCNT_OFS = 8'h10;

    // Control register fields.
    localparam int CTRL_DIR_BIT  = 0;
    localparam int CTRL_SIZE_BIT = 1;
    localparam int CTRL_IMP_BIT  = 2;
    localparam int CTRL_OPEN_BIT = 3;
    localparam int CTRL_W        = 4;

    // Status register fields.
    localparam int STAT_PH_LSB   = 0;
    localparam int STAT_HOME_BIT = 3;
    localparam int STAT_HS_LSB   = 4;
    localparam int STAT_LS_LSB   = 8;
    localparam int STAT_OPEN_BIT = 12;

    // Reset values; the set line starts open so the coils stay off until released.
    localparam logic [3:0]  CTRL_RST = 4'h8;
    localparam logic [7:0]  BIAS_RST = 8'h80;
    localparam logic [15:0] CNT_RST  = 16'h0000;

    // Coil pattern per phase, one bit per phase A..H (bit 0 is A).
    localparam logic [7:0] COIL1_ON  = 8'hDD;
    localparam logic [7:0] COIL1_POS = 8'hC1;
    localparam logic [7:0] COIL2_ON  = 8'h77;
    localparam logic [7:0] COIL2_POS = 8'h07;

    // Switch patterns that show phase A at the coil outputs.
    localparam logic [3:0] PHA_HS = 4'h5;
    localparam logic [3:0] PHA_LS = 4'hA;

    // Sequencer phase, half-step numbering.
    typedef enum logic [2:0] {
        BPS_PH_A = 3'h0,
        BPS_PH_B = 3'h1,
        BPS_PH_C = 3'h2,
        BPS_PH_D = 3'h3,
        BPS_PH_E = 3'h4,
        BPS_PH_F = 3'h5,
        BPS_PH_G = 3'h6,
        BPS_PH_H = 3'h7
    } bps_phase_t;

endpackage

/* File: hw/bps_sequencer.sv */
// Stepper phase sequencer with AHB-Lite register access and coil switch outputs.
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps

module bps_sequencer (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        step_clk_pin,
    output logic      [3:0]  coil_hs_on,
    output logic      [3:0]  coil_ls_on,
    output logic             home_phase_indicator_o,
    output logic             home_phase_indicator_oe_n,
    output logic      [7:0]  bias_current
);

    bps_drv_if drv ();

    logic [bps_pkg::CTRL_W-1:0] ctrl_r;
    logic [7:0]                 bias_r;
    logic [15:0]                step_cnt_r;
    logic [31:0]                hrdata_r;
    logic [31:0]                rd_nxt;
    logic [7:0]                 addr_r;
    logic                       wr_pend_r;
    logic                       rd_wait_r;
    logic                       step_s1_r;
    logic                       step_s2_r;
    logic                       step_s3_r;
    logic                       accept;
    logic                       wr_en;
    logic                       step_wr;
    logic                       pin_rise;
    logic                       step_go;
    logic                       set_open;
    logic                       dir_desc;
    logic                       half_mode;
    bps_pkg::bps_phase_t        phase_r;

    // Next phase from the present one, the direction and the step size.
    function automatic bps_pkg::bps_phase_t next_phase(
        input bps_pkg::bps_phase_t p,
        input logic                desc,
        input logic                half
    );
        logic [2:0] delta;
        delta = 3'h0;
        if (half)
            delta = desc ? 3'h7 : 3'h1;
        else if (p[0])
            delta = desc ? 3'h7 : 3'h1;
        else
            delta = desc ? 3'h6 : 3'h2;
        return bps_pkg::bps_phase_t'(3'(p + delta));
    endfunction

    // Control fields as the sequencer sees them.
    assign set_open  = ctrl_r[bps_pkg::CTRL_OPEN_BIT];
    assign dir_desc  = ctrl_r[bps_pkg::CTRL_DIR_BIT];
    assign half_mode = ctrl_r[bps_pkg::CTRL_SIZE_BIT];

    // Bus address phase is taken on a selected, ready, non-idle transfer.
    assign accept  = hsel && hready && htrans[1];
    assign wr_en   = wr_pend_r;
    assign step_wr = wr_en && (addr_r == bps_pkg::STEP_OFS) && hwdata[0];

    // Reads insert one wait state so that a write just before is visible.
    assign hreadyout = !rd_wait_r;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    // Address phase capture.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            addr_r    <= 8'h00;
            wr_pend_r <= 1'b0;
            rd_wait_r <= 1'b0;
        end
        else
        begin
            if (hreadyout)
            begin
                addr_r    <= accept ? {haddr[7:2], 2'b00} : addr_r;
                wr_pend_r <= accept && hwrite;
                rd_wait_r <= accept && !hwrite;
            end
            else
            begin
                wr_pend_r <= 1'b0;
                rd_wait_r <= 1'b0;
            end
        end
    end

    // Read multiplexer; unmapped offsets read as zero.
    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        unique case (addr_r)
            bps_pkg::CTRL_OFS:
                rd_nxt[bps_pkg::CTRL_W-1:0] = ctrl_r;
            bps_pkg::BIAS_OFS:
                rd_nxt[7:0] = bias_r;
            bps_pkg::STATUS_OFS:
            begin
                rd_nxt[bps_pkg::STAT_PH_LSB +: 3]  = phase_r;
                rd_nxt[bps_pkg::STAT_HOME_BIT]     = drv.home_on;
                rd_nxt[bps_pkg::STAT_HS_LSB +: 4]  = drv.hs_on;
                rd_nxt[bps_pkg::STAT_LS_LSB +: 4]  = drv.ls_on;
                rd_nxt[bps_pkg::STAT_OPEN_BIT]     = set_open;
            end
            bps_pkg::STEPCNT_OFS:
                rd_nxt[15:0] = step_cnt_r;
            default:
                rd_nxt = 32'h0000_0000;
        endcase
    end

    // Read data register, loaded in the wait state.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_r <= 32'h0000_0000;
        else if (rd_wait_r)
            hrdata_r <= rd_nxt;
    end

    // Control register; the set line starts open as a power-up hold.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl_r <= bps_pkg::CTRL_RST;
        else if (wr_en && addr_r == bps_pkg::CTRL_OFS)
            ctrl_r <= hwdata[bps_pkg::CTRL_W-1:0];
    end

    // Bias current level; a standby value leaves the phase alone.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            bias_r <= bps_pkg::BIAS_RST;
        else if (wr_en && addr_r == bps_pkg::BIAS_OFS)
            bias_r <= hwdata[7:0];
    end

    assign bias_current = bias_r;

    // Step pin synchroniser and rising edge detector.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            step_s1_r <= 1'b0;
            step_s2_r <= 1'b0;
            step_s3_r <= 1'b0;
        end
        else
        begin
            step_s1_r <= step_clk_pin;
            step_s2_r <= step_s1_r;
            step_s3_r <= step_s2_r;
        end
    end

    assign pin_rise = step_s2_r && !step_s3_r;
    assign step_go  = (pin_rise || step_wr) && !set_open;

    // Phase sequencer; the open set line presets phase A.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            phase_r <= bps_pkg::BPS_PH_A;
        else if (set_open)
            phase_r <= bps_pkg::BPS_PH_A;
        else if (step_go)
            phase_r <= next_phase(phase_r, dir_desc, half_mode);
    end

    // Count of steps taken; a write to the counter clears it.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            step_cnt_r <= bps_pkg::CNT_RST;
        else if (wr_en && addr_r == bps_pkg::STEPCNT_OFS)
            step_cnt_r <= bps_pkg::CNT_RST;
        else if (step_go)
            step_cnt_r <= 16'(step_cnt_r + 16'h0001);
    end

    // Decoder hookup.
    assign drv.phase      = phase_r;
    assign drv.half_mode  = half_mode;
    assign drv.idle_low_z = ctrl_r[bps_pkg::CTRL_IMP_BIT];
    assign drv.set_open   = set_open;

    bps_coil_decode u_dec (
        .hclk    (hclk),
        .hresetn (hresetn),
        .drv     (drv)
    );

    // Coil and indicator pins; the indicator pulls low in phase A and while the set line is open.
    assign coil_hs_on                = drv.hs_on;
    assign coil_ls_on                = drv.ls_on;
    assign home_phase_indicator_o    = 1'b0;
    assign home_phase_indicator_oe_n = !drv.home_on;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_open_held;
        set_open [*2];
    endsequence

    sequence s_release;
        $past(set_open) && !set_open;
    endsequence

    // A read data phase is one wait state followed by the ready cycle.
    sequence s_read_wait;
        !hreadyout ##1 hreadyout;
    endsequence

    AST_FULL_STEP_EVEN: assert property (step_go && !half_mode && !phase_r[0] |=>
        phase_r == 3'($past(phase_r) + ($past(dir_desc) ? 3'h6 : 3'h2)))
        else $error("Full step from even phase went wrong.");
    AST_HALF_STEP: assert property (step_go && half_mode |=>
        phase_r == 3'($past(phase_r) + ($past(dir_desc) ? 3'h7 : 3'h1)))
        else $error("Half step went wrong.");
    AST_MODE_CHANGE_ADJ: assert property (step_go && !half_mode && phase_r[0] |=>
        !phase_r[0] && phase_r == 3'($past(phase_r) + ($past(dir_desc) ? 3'h7 : 3'h1)))
        else $error("Step from odd phase in full mode not adjacent.");
    AST_OPEN_PRESET: assert property (set_open |=> phase_r == bps_pkg::BPS_PH_A)
        else $error("Open set line did not hold phase A.");
    AST_OPEN_HIZ: assert property (s_open_held |-> coil_hs_on == 4'h0 && coil_ls_on == 4'h0)
        else $error("Coils driven while set line open.");
    AST_OPEN_IGNORES: assert property (set_open |=> $stable(step_cnt_r) || step_cnt_r == 16'h0000)
        else $error("Step taken while set line open.");
    AST_RELEASE_PHASE_A: assert property (s_release |=> coil_hs_on == bps_pkg::PHA_HS &&
        coil_ls_on == bps_pkg::PHA_LS && !home_phase_indicator_oe_n)
        else $error("Release did not show phase A.");
    AST_HOME_EXACT: assert property (##1 !set_open && !$past(set_open) |->
        (!home_phase_indicator_oe_n == (coil_hs_on == bps_pkg::PHA_HS && coil_ls_on == bps_pkg::PHA_LS)))
        else $error("Home indicator disagrees with coil outputs.");
    AST_STANDBY_NO_PRESET: assert property (wr_en && addr_r == bps_pkg::BIAS_OFS && !set_open && !step_go |=>
        $stable(phase_r))
        else $error("Bias write changed the phase.");
    AST_STEP_MOVES: assert property (step_go |=> phase_r != $past(phase_r))
        else $error("Step edge did not move the phase.");

    // The indicator must be active in the first cycle in which the outputs are switched off by the set line.
    AST_HOME_WHILE_OPEN: assert property (set_open |=> !home_phase_indicator_oe_n)
        else $error("Home indicator inactive while set line open.");

    // A synchronised pin edge with the set line closed counts exactly one step.
    AST_PIN_COUNTS: assert property (pin_rise && !set_open && !(wr_en && addr_r == bps_pkg::STEPCNT_OFS) |=>
        step_cnt_r == 16'($past(step_cnt_r) + 16'h0001))
        else $error("Pin edge not counted as one step.");

    // Every accepted read sees one wait state before its data.
    AST_READ_ONE_WAIT: assert property (accept && hreadyout && !hwrite |=> s_read_wait)
        else $error("Read data phase length wrong.");

endmodule
